// ### src/desc_channel.sv
// Purpose: Linked descriptor fetch channel with AXI4-Lite registers
// Assumes: Memory read port answers with a one-cycle ack and data
// Notes:   CE_I low freezes all state, bus answers included
// Function
// R01 - Bits 28:27 select next descriptor layout
// R02 - Bit 26 set loads destination, else kept
// R03 - Bit 25 set loads source, else kept
// R04 - Bit 24 set fetches next, else stop
// R05 - Control word is only read, never written
// R06 - Bits 23:0 load the transfer length counter
// R07 - Descriptor address word aligned, bits 1:0 ignored
// R08 - Address bit 0 selects fetch interface
`timescale 1ns/100ps
`default_nettype none
module desc_channel
	import desc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic MEM_REQ_O,
	output logic [31:0] MEM_ADDR_O,
	output logic MEM_PORT_O,
	input wire logic MEM_ACK_I,
	input wire logic [31:0] MEM_RDATA_I,
	input wire logic BEAT_I,
	output logic BUSY_O,
	output logic DONE_O,
	output logic [31:0] SRC_PARAM_O,
	output logic [31:0] DST_PARAM_O
);
	// --------------------------------------------------
	// State
	// --------------------------------------------------
	fetch_state_t state_q, state_d;
	logic [1:0] w_q, w_d;
	logic [31:0] addr_q, addr_d;
	logic port_q, port_d;
	logic [31:0] link_q, link_d;
	logic [31:0] ctrl_q, ctrl_d;
	logic [31:0] src_q, src_d;
	logic [31:0] dst_q, dst_d;
	logic [23:0] len_q, len_d;
	logic [1:0] view_q, view_d;
	logic [1:0] sview_q, sview_d;
	logic done_q, done_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [1:0] rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic wr_take, rd_take, start;
	logic [31:0] status;

	desc_ctrl_if dec_bus ();

	desc_ctrl_decode u_decode (
		.bus(dec_bus)
	);

	assign dec_bus.descriptor_control_word = ctrl_q;

	// Merge write data into a word under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[8*i +: 8] = val[8*i +: 8];
			end
		end
	endfunction

	// --------------------------------------------------
	// Bus handshakes and outputs
	// --------------------------------------------------
	assign S_AXI_AWREADY = CE_I && S_AXI_AWVALID && S_AXI_WVALID && !bvalid_q;
	assign S_AXI_WREADY = CE_I && S_AXI_AWVALID && S_AXI_WVALID && !bvalid_q;
	assign S_AXI_ARREADY = CE_I && !rvalid_q;
	assign wr_take = CE_I && S_AXI_AWREADY;
	assign rd_take = CE_I && S_AXI_ARVALID && !rvalid_q;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RRESP = rresp_q;
	assign S_AXI_RDATA = rdata_q;
	assign MEM_REQ_O = (state_q == ST_FETCH);
	assign MEM_ADDR_O = addr_q;
	assign MEM_PORT_O = port_q;
	assign BUSY_O = (state_q != ST_IDLE);
	assign DONE_O = done_q;
	assign SRC_PARAM_O = src_q;
	assign DST_PARAM_O = dst_q;
	assign status = {25'h0, port_q, dec_bus.next_fetch_enable,
		dec_bus.src_param_update, dec_bus.dest_param_update, view_q, BUSY_O};

	// --------------------------------------------------
	// Next state
	// --------------------------------------------------
	always_comb begin
		state_d = state_q;
		w_d = w_q;
		addr_d = addr_q;
		port_d = port_q;
		link_d = link_q;
		ctrl_d = ctrl_q;
		src_d = src_q;
		dst_d = dst_q;
		len_d = len_q;
		view_d = view_q;
		sview_d = sview_q;
		done_d = 1'b0;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		start = 1'b0;
		if (bvalid_q && S_AXI_BREADY) begin
			bvalid_d = 1'b0;
		end
		if (wr_take) begin
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			case (8'(S_AXI_AWADDR))
				OFS_CTRL: begin
					if (S_AXI_WSTRB[0]) begin
						sview_d = S_AXI_WDATA[CTRL_VIEW_LO +: 2];
						start = S_AXI_WDATA[CTRL_START_BIT] && (state_q == ST_IDLE);
					end
				end
				OFS_NEXT_ADDR: begin
					if (state_q == ST_IDLE) begin
						link_d = merge(link_q, S_AXI_WDATA, S_AXI_WSTRB)
							& NEXT_ADDR_MASK;
					end
				end
				OFS_STATUS, OFS_LEN, OFS_SRC, OFS_DST: begin
					bresp_d = RESP_OKAY;
				end
				default: begin
					bresp_d = RESP_SLVERR;
				end
			endcase
		end
		if (rvalid_q && S_AXI_RREADY) begin
			rvalid_d = 1'b0;
		end
		if (rd_take) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			case (8'(S_AXI_ARADDR))
				OFS_CTRL: rdata_d = {29'h0, sview_q, 1'b0};
				OFS_STATUS: rdata_d = status;
				OFS_LEN: rdata_d = {8'h00, len_q};
				OFS_SRC: rdata_d = src_q;
				OFS_DST: rdata_d = dst_q;
				OFS_NEXT_ADDR: rdata_d = link_q;
				default: begin
					rdata_d = RST_WORD;
					rresp_d = RESP_SLVERR;
				end
			endcase
		end
		case (state_q)
			ST_IDLE: begin
				if (start) begin
					view_d = sview_d;
					state_d = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (MEM_ACK_I) begin
					case (w_q)
						WORD_LINK: link_d = MEM_RDATA_I & NEXT_ADDR_MASK;
						WORD_CTRL: ctrl_d = MEM_RDATA_I; // see R05
						WORD_SRC: begin
							if (dec_bus.src_param_update) begin
								src_d = MEM_RDATA_I; // see R03
							end
						end
						default: begin
							if (dec_bus.dest_param_update) begin
								dst_d = MEM_RDATA_I; // see R02
							end
						end
					endcase
					addr_d = addr_q + 32'h4;
					w_d = w_q + 2'h1;
					if (w_q == last_word(view_q)) begin // see R01
						state_d = ST_LOAD;
					end
				end
			end
			ST_LOAD: begin
				len_d = dec_bus.microblock_length; // see R06
				view_d = dec_bus.next_view_select; // see R01
				state_d = ST_RUN;
			end
			ST_RUN: begin
				if (len_q == 24'h0) begin
					if (dec_bus.next_fetch_enable) begin
						state_d = ST_FETCH; // see R04
					end else begin
						state_d = ST_IDLE; // see R04
						done_d = 1'b1;
					end
				end else if (BEAT_I) begin
					len_d = len_q - 24'h1;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		if (state_d == ST_FETCH && state_q != ST_FETCH) begin
			w_d = WORD_LINK;
			addr_d = {link_q[31:2], 2'b00}; // see R07
			port_d = link_q[PORT_SEL_BIT]; // see R08
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			state_q <= ST_IDLE;
			w_q <= WORD_LINK;
			addr_q <= RST_WORD;
			port_q <= 1'b0;
			link_q <= RST_WORD;
			ctrl_q <= RST_WORD;
			src_q <= RST_WORD;
			dst_q <= RST_WORD;
			len_q <= 24'h0;
			view_q <= 2'h0;
			sview_q <= 2'h0;
			done_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= RST_WORD;
		end else if (CE_I) begin
			state_q <= state_d;
			w_q <= w_d;
			addr_q <= addr_d;
			port_q <= port_d;
			link_q <= link_d;
			ctrl_q <= ctrl_d;
			src_q <= src_d;
			dst_q <= dst_d;
			len_q <= len_d;
			view_q <= view_d;
			sview_q <= sview_d;
			done_q <= done_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	// --------------------------------------------------
	// Checks
	// --------------------------------------------------
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I);

	logic ack_ce;
	assign ack_ce = CE_I && MEM_REQ_O && MEM_ACK_I;

	a_view_words: assert property (MEM_REQ_O |-> w_q <= last_word(view_q)) // see R01
		else $error("descriptor word index beyond layout");
	a_dst_update: assert property (ack_ce && w_q == WORD_DST // see R02
		|=> dst_q == ($past(dec_bus.dest_param_update) ?
		$past(MEM_RDATA_I) : $past(dst_q)))
		else $error("destination parameters wrong after fetch");
	a_src_update: assert property (ack_ce && w_q == WORD_SRC // see R03
		|=> src_q == ($past(dec_bus.src_param_update) ?
		$past(MEM_RDATA_I) : $past(src_q)))
		else $error("source parameters wrong after fetch");
	a_fetch_stop: assert property (CE_I && state_q == ST_RUN && len_q == 24'h0 // see R04
		|=> state_q == ($past(dec_bus.next_fetch_enable) ? ST_FETCH : ST_IDLE))
		else $error("fetch decision ignores enable flag");
	a_ctrl_source: assert property (CE_I && state_q != ST_FETCH |=> $stable(ctrl_q)) // see R05
		else $error("control word changed outside fetch");
	a_len_load: assert property (CE_I && state_q == ST_LOAD // see R06
		|=> len_q == $past(ctrl_q[LEN_W-1:0]) && state_q == ST_RUN)
		else $error("length counter not loaded");
	a_addr_align: assert property (MEM_REQ_O |-> MEM_ADDR_O[1:0] == 2'b00) // see R07
		else $error("descriptor address not word aligned");
	a_port_sel: assert property (CE_I && state_q != ST_FETCH && state_d == ST_FETCH // see R08
		|=> MEM_PORT_O == $past(link_q[PORT_SEL_BIT]))
		else $error("fetch interface does not follow select bit");
	a_bresp_hold: assert property (bvalid_q && !S_AXI_BREADY |=> bvalid_q)
		else $error("write response dropped");

	c_chain: cover property (state_q == ST_RUN && len_q == 24'h0 &&
		dec_bus.next_fetch_enable ##1 state_q == ST_FETCH);
	c_stop: cover property (DONE_O);
	c_full_view: cover property (ack_ce && w_q == WORD_DST);
endmodule
`default_nettype wire

// ### src/desc_pkg.sv
// Purpose: Shared constants and types of the descriptor fetch channel
// Assumes: One channel, 32-bit AXI4-Lite register access
// Notes:   Offsets are byte addresses
package desc_pkg;
	// --------------------------------------------------
	// Register offsets
	// --------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_LEN = 8'h08;
	localparam logic [7:0] OFS_SRC = 8'h0C;
	localparam logic [7:0] OFS_DST = 8'h10;
	localparam logic [7:0] OFS_NEXT_ADDR = 8'h68;
	// --------------------------------------------------
	// Control word fields
	// --------------------------------------------------
	localparam int VIEW_HI = 28;
	localparam int VIEW_LO = 27;
	localparam int DST_UPD_BIT = 26;
	localparam int SRC_UPD_BIT = 25;
	localparam int FETCH_EN_BIT = 24;
	localparam int LEN_W = 24;
	localparam int PORT_SEL_BIT = 0;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_VIEW_LO = 1;
	// --------------------------------------------------
	// Reset values and codes
	// --------------------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [31:0] NEXT_ADDR_MASK = 32'hFFFF_FFFD;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] WORD_LINK = 2'h0;
	localparam logic [1:0] WORD_CTRL = 2'h1;
	localparam logic [1:0] WORD_SRC = 2'h2;
	localparam logic [1:0] WORD_DST = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_LOAD = 2'b10,
		ST_RUN = 2'b11
	} fetch_state_t;

	// Index of the last word of a descriptor in a given layout
	function automatic logic [1:0] last_word(input logic [1:0] view);
		case (view)
			2'h0: last_word = WORD_CTRL;
			2'h1: last_word = WORD_SRC;
			default: last_word = WORD_DST;
		endcase
	endfunction
endpackage

// ### src/desc_ctrl_if.sv
// Purpose: Carries a descriptor control word and its decoded fields
// Assumes: Decoder drives the fields, channel drives the word
// Notes:   None
`timescale 1ns/100ps
`default_nettype none
interface desc_ctrl_if;
	logic [31:0] descriptor_control_word;
	logic [1:0] next_view_select;
	logic dest_param_update;
	logic src_param_update;
	logic next_fetch_enable;
	logic [23:0] microblock_length;
	modport dec (
		input descriptor_control_word,
		output next_view_select, dest_param_update, src_param_update,
		output next_fetch_enable, microblock_length
	);
	modport user (
		output descriptor_control_word,
		input next_view_select, dest_param_update, src_param_update,
		input next_fetch_enable, microblock_length
	);
endinterface
`default_nettype wire

// ### src/desc_ctrl_decode.sv
// Purpose: Splits a descriptor control word into its fields
// Assumes: Word is stable for the cycle it is used
// Notes:   Purely combinational
`timescale 1ns/100ps
`default_nettype none
module desc_ctrl_decode
	import desc_pkg::*;
(
	desc_ctrl_if.dec bus
);
	assign bus.next_view_select = bus.descriptor_control_word[VIEW_HI:VIEW_LO]; // see R01
	assign bus.dest_param_update = bus.descriptor_control_word[DST_UPD_BIT]; // see R02
	assign bus.src_param_update = bus.descriptor_control_word[SRC_UPD_BIT]; // see R03
	assign bus.next_fetch_enable = bus.descriptor_control_word[FETCH_EN_BIT]; // see R04
	assign bus.microblock_length = bus.descriptor_control_word[LEN_W-1:0]; // see R06
endmodule
`default_nettype wire

// ### testbench/desc_mem.sv
// Purpose: Descriptor memory behind the channel read port
// Assumes: Word index from address bits 9:2
// Notes:   Read-only, answer delay set through dly
`timescale 1ns/100ps
`default_nettype none
module desc_mem (
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic [31:0] addr_i,
	input wire logic port_i,
	output logic ack_o,
	output logic [31:0] data_o
);
	logic [31:0] mem [0:255];
	logic [1:0] seen [0:255];
	int dly;
	int cnt;
	initial begin
		ack_o = 1'b0;
		data_o = 32'h0;
		dly = 0;
		cnt = 0;
		for (int i = 0; i < 256; i++) begin
			seen[i] = 2'h0;
		end
	end
	// ----------------------------------------
	// Answer one word per request
	// ----------------------------------------
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		data_o <= ~data_o;
		if (req_i && !ack_o) begin
			if (cnt >= dly) begin
				ack_o <= 1'b1;
				data_o <= mem[addr_i[9:2]];
				seen[addr_i[9:2]] <= {1'b1, port_i};
				cnt <= 0;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Purpose: Self-checking bench of the descriptor channel
// Assumes: Three linked descriptors preloaded in the memory model
// Notes:   Bus tasks hold each channel until its handshake
`timescale 1ns/100ps
`default_nettype none
module tb
	import desc_pkg::*;
;
	logic mclk, rst, ce, awvalid, wvalid, bready, arvalid, rready, beat;
	logic awready, wready, bvalid, arready, rvalid, req, port, ack, busy;
	logic done;
	logic [7:0] awaddr, araddr;
	logic [1:0] bresp, rresp;
	logic [31:0] wdata, rdata, maddr, mdata, srcp, dstp;
	int err_total, num_checks;

	desc_channel dut (
		.MCLK_I(mclk), .RST_I(rst), .CE_I(ce),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.MEM_REQ_O(req), .MEM_ADDR_O(maddr), .MEM_PORT_O(port),
		.MEM_ACK_I(ack), .MEM_RDATA_I(mdata), .BEAT_I(beat),
		.BUSY_O(busy), .DONE_O(done), .SRC_PARAM_O(srcp), .DST_PARAM_O(dstp)
	);
	desc_mem mem_i (.clk_i(mclk), .req_i(req), .addr_i(maddr),
		.port_i(port), .ack_o(ack), .data_o(mdata));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic complete_run();
		if (err_total == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ----------------------------------------
	// Bus and stimulus tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw || w) begin
			@(posedge mclk);
			if (aw && awready === 1'b1) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) begin
			@(posedge mclk);
		end
		chk({30'h0, bresp}, {30'h0, r});
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m, input logic [1:0] r);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) begin
			@(posedge mclk);
		end
		chk(rdata & m, e);
		chk({30'h0, rresp}, {30'h0, r});
		rready <= 1'b0;
	endtask
	task automatic beats(input int k);
		repeat (k) begin
			@(posedge mclk);
			beat <= 1'b1;
			@(posedge mclk);
			beat <= 1'b0;
		end
	endtask
	task automatic wait_sig(input int which, input logic v);
		while ((which == 0 ? req : done) !== v) begin
			@(posedge mclk);
		end
	endtask
	task automatic fetched();
		wait_sig(0, 1'b1);
		wait_sig(0, 1'b0);
		repeat (2) @(posedge mclk);
	endtask
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, beat} = 6'h0;
		{awaddr, araddr, wdata} = 48'h0;
		mem_i.mem[64] = 32'h0000_0200;
		mem_i.mem[65] = 32'hE900_0002;
		mem_i.mem[66] = 32'h5555_5555;
		mem_i.mem[128] = 32'h0000_0301;
		mem_i.mem[129] = 32'h1300_0001;
		mem_i.mem[130] = 32'h1111_1111;
		mem_i.mem[131] = 32'h4444_4444;
		mem_i.mem[192] = 32'h0000_0000;
		mem_i.mem[193] = 32'h1C00_0000;
		mem_i.mem[194] = 32'h2222_2222;
		mem_i.mem[195] = 32'h3333_3333;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		rd(OFS_STATUS, 32'h0, 32'hFFFF_FFFF, RESP_OKAY);
		rd(OFS_NEXT_ADDR, 32'h0, 32'hFFFF_FFFF, RESP_OKAY);
		rd(8'h20, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
		wr(8'h24, 32'h0000_0001, RESP_SLVERR);
		wr(OFS_NEXT_ADDR, 32'h0000_0103, RESP_OKAY);
		rd(OFS_NEXT_ADDR, 32'h0000_0101, 32'hFFFF_FFFF, RESP_OKAY);
		wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
		fetched();
		rd(OFS_LEN, 32'h2, 32'hFFFF_FFFF, RESP_OKAY);
		rd(OFS_STATUS, 32'h61, 32'h79, RESP_OKAY);
		chk(srcp, 32'h0);
		chk(dstp, 32'h0);
		wr(OFS_NEXT_ADDR, 32'h0000_0400, RESP_OKAY);
		mem_i.dly = 3;
		beats(2);
		fetched();
		rd(OFS_LEN, 32'h1, 32'hFFFF_FFFF, RESP_OKAY);
		rd(OFS_STATUS, 32'h31, 32'h79, RESP_OKAY);
		chk(srcp, 32'h1111_1111);
		chk(dstp, 32'h0);
		ce <= 1'b0;
		beats(1);
		ce <= 1'b1;
		rd(OFS_LEN, 32'h1, 32'hFFFF_FFFF, RESP_OKAY);
		mem_i.dly = 0;
		beats(1);
		wait_sig(1, 1'b1);
		chk({31'h0, busy}, 32'h0);
		@(posedge mclk);
		chk({31'h0, done}, 32'h0);
		chk(srcp, 32'h1111_1111);
		chk(dstp, 32'h3333_3333);
		for (int i = 0; i < 4; i++) begin
			chk({30'h0, mem_i.seen[64 + i]}, i < 2 ? 32'h3 : 32'h0);
			chk({30'h0, mem_i.seen[128 + i]}, i < 3 ? 32'h2 : 32'h0);
			chk({30'h0, mem_i.seen[192 + i]}, 32'h3);
		end
		repeat (10) @(posedge mclk);
		chk({31'h0, req}, 32'h0);
		wr(OFS_CTRL, 32'h0000_0006, RESP_OKAY);
		rd(OFS_CTRL, 32'h6, 32'hFFFF_FFFF, RESP_OKAY);
		rd(OFS_STATUS, 32'h0, 32'h01, RESP_OKAY);
		complete_run();
	end
	initial begin
		#300000;
		err_total++;
		complete_run();
	end
endmodule
`default_nettype wire
